// File: chpm_port.sv
// chpm_port: host port mode logic of the storage card
// assumes host pins are asynchronous and software sits on APB
`timescale 1ns/10ps
module chpm_port
  import chpm_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire chpm_pins_s host_pins_in,
  output logic [7:0] data_lo_out,
  output logic data_lo_oe_out,
  input wire logic multi_status_in,
  output logic multi_status_out,
  output logic multi_status_oe_out,
  output logic io_channel_ready_out,
  output logic io_channel_ready_oe_out,
  output logic [1:0] mode_out,
  output logic master_out,
  output logic word_access_out,
  output logic [2:0] task_index_out,
  output logic [2:0] region_out
);
  // ==========================================
  // pin synchronisers
  chpm_pins_s s1, s2, s3, pins, pins_q;
  logic d1, d2, d3, diag_f;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      pins <= '1;
      pins_q <= '1;
      d1 <= 1'b1;
      d2 <= 1'b1;
      d3 <= 1'b1;
      diag_f <= 1'b1;
    end else begin
      s1 <= host_pins_in;
      s2 <= s1;
      s3 <= s2;
      pins <= chpm_pins_s'((s2 & s3) | (pins & (s2 | s3)));
      pins_q <= pins;
      d1 <= multi_status_in;
      d2 <= d1;
      d3 <= d2;
      diag_f <= (d2 & d3) | (diag_f & (d2 | d3));
    end
  end

  // ==========================================
  // registers and state
  chpm_mode_e mode, next_mode;
  chpm_region_e region, region_q;
  logic [2:0] settle;
  logic [CTL_W-1:0] ctrl;
  logic [7:0] option, ccsr;
  logic changed, rdy_q, wp_q;
  logic [10:0] last_addr;

  // ==========================================
  // apb decode
  wire apb_setup = psel_in & ~penable_in;
  wire apb_wr = psel_in & penable_in & pwrite_in;
  wire hit_ctrl = (paddr_in == REG_CTRL);
  wire hit_stat = (paddr_in == REG_STAT);
  wire hit_conf = (paddr_in == REG_CONF);
  wire hit_addr = (paddr_in == REG_ADDR);
  wire hit_any = hit_ctrl | hit_stat | hit_conf | hit_addr;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit_any;

  // ==========================================
  // mode and host decode
  wire settled = (settle == SETTLE_CYC);
  wire disk = (mode == MD_DISK);
  wire memio = (mode == MD_MEM) | (mode == MD_IO);
  wire io_sel = (option[OPT_IDX_MSB:0] != '0);
  wire attr = ~pins.reg_n;
  wire card_sel = ~pins.ce1_n | ~pins.card_enable_upper_n;
  wire io_strobe = ~pins.iord_n | ~pins.iowr_n;
  wire cfg_hit = (pins.addr[10:9] == ATTR_CFG_TOP);
  wire udma = disk & ctrl[CTL_UDMA];
  wire we_rise = ~pins_q.we_n & pins.we_n;
  wire cfg_wr = memio & we_rise & (region_q == RG_CONFIG);
  wire opt_wr = cfg_wr & (pins_q.addr == ATTR_OPTION);
  wire ccsr_wr = cfg_wr & (pins_q.addr == ATTR_CCSR);
  wire clr_changed = ccsr_wr & pins_q.data[CCSR_CHANGED];
  wire chg_evt = (mode == MD_IO) & ((ctrl[CTL_RDY] ^ rdy_q) | (ctrl[CTL_WP] ^ wp_q));
  wire status_changed_n_n = ~(changed & ccsr[CCSR_SIGCHG]);
  wire cfg_rd = memio & ~pins.oe_n & (region == RG_CONFIG);
  wire [7:0] cfg_rdata = (pins.addr == ATTR_OPTION) ? option :
                         (pins.addr == ATTR_CCSR) ? {changed, ccsr[6:0]} : 8'h00;
  wire dma_ack = disk & ctrl[CTL_DMAEN] & ~pins.reg_n;
  // write: read strobe is host data strobe
  wire host_data_strobe = udma & ctrl[CTL_UWR] & pins.iord_n;
  // read: read strobe is host ready
  wire host_ready_for_data = udma & ~ctrl[CTL_UWR] & pins.iord_n;
  // data register only uses word bus
  wire disk_word = ~pins.ce1_n & (pins.addr[2:0] == 3'h0);
  // upper enable marks odd byte or word
  wire mem_word = ~pins.card_enable_upper_n & ~pins.ce1_n;
  wire [31:0] stat_word = {17'h0, region_q, task_index_out, 2'h0, dma_ack,
                           host_ready_for_data, host_data_strobe, diag_f,
                           master_out, mode};
  wire [31:0] rd_mux = hit_ctrl ? {{(32 - CTL_W){1'b0}}, ctrl} :
                       hit_stat ? stat_word :
                       hit_conf ? {16'h0, changed, ccsr[6:0], option} :
                       hit_addr ? {21'h0, last_addr} : 32'h0;

  // region decode in disk, memory and io modes
  always_comb begin
    region = RG_NONE;
    if (disk) begin
      if (card_sel) begin
        region = RG_TASK;
      end
    end else if (memio && card_sel) begin
      if (mode == MD_IO && io_strobe) begin
        region = RG_IOPORT;
      end else if (attr && cfg_hit) begin
        region = RG_CONFIG;
      end else if (attr) begin
        region = RG_CIS;
      end else begin
        region = RG_MEMPORT;
      end
    end
  end

  always_comb begin
    next_mode = mode;
    case (mode)
      MD_INIT: begin
        if (settled) begin
          next_mode = pins.oe_n ? MD_MEM : MD_DISK;
        end
      end
      MD_MEM: begin
        if (io_sel) begin
          next_mode = MD_IO;
        end
      end
      MD_IO: begin
        if (!io_sel) begin
          next_mode = MD_MEM;
        end
      end
      MD_DISK: next_mode = MD_DISK;
      default: next_mode = MD_INIT;
    endcase
  end

  // ==========================================
  // state registers
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode <= MD_INIT;
      settle <= 3'h0;
    end else begin
      mode <= next_mode;
      if (!settled) begin
        settle <= settle + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl <= CTRL_RST[CTL_W-1:0];
      prdata_out <= 32'h0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        ctrl <= pwdata_in[CTL_W-1:0];
      end
      if (apb_setup) begin
        prdata_out <= rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      option <= OPT_RST;
      ccsr <= CCSR_RST;
      changed <= 1'b0;
      rdy_q <= 1'b1;
      wp_q <= 1'b0;
    end else begin
      rdy_q <= ctrl[CTL_RDY];
      wp_q <= ctrl[CTL_WP];
      if (opt_wr) begin
        option <= pins_q.data;
      end
      if (ccsr_wr) begin
        ccsr <= pins_q.data;
      end
      // set wins over the host clear
      changed <= chg_evt | (changed & ~clr_changed);
    end
  end

  // ==========================================
  // host side outputs
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      region_q <= RG_NONE;
      task_index_out <= 3'h0;
      last_addr <= 11'h0;
      data_lo_out <= 8'h00;
      data_lo_oe_out <= 1'b0;
      master_out <= 1'b0;
      word_access_out <= 1'b0;
    end else begin
      region_q <= region;
      if (region != RG_NONE) begin
        last_addr <= pins.addr;
      end
      // three low lines pick task register
      if (disk) begin
        task_index_out <= pins.addr[2:0];
      end
      data_lo_out <= cfg_rd ? cfg_rdata : 8'h00;
      data_lo_oe_out <= cfg_rd;
      master_out <= disk & ~pins.cable_select_n;
      word_access_out <= disk ? disk_word : (memio & mem_word);
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      multi_status_out <= 1'b1;
      multi_status_oe_out <= 1'b0;
      io_channel_ready_out <= 1'b0;
      io_channel_ready_oe_out <= 1'b0;
    end else begin
      // battery detect high in memory mode
      multi_status_out <= (mode == MD_IO) ? status_changed_n_n : ~disk;
      multi_status_oe_out <= disk ? ctrl[CTL_DIAG] : memio;
      if (udma) begin
        io_channel_ready_out <= ctrl[CTL_WAIT];
        io_channel_ready_oe_out <= 1'b1;
      end else begin
        io_channel_ready_out <= 1'b0;
        io_channel_ready_oe_out <= ~ctrl[CTL_WAIT];
      end
    end
  end

  assign mode_out = mode;
  // region decoded on the previous clock, none when idle
  assign region_out = region_q;

  // ==========================================
  // checks
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_mode_from_oe: assert property (
    (mode == MD_INIT && settled && !pins.oe_n) |=> (mode == MD_DISK))
    else $error("disk mode not entered");
  a_mode_kept_disk: assert property (
    (mode == MD_DISK) |=> (mode == MD_DISK) [*4])
    else $error("disk mode left");
  a_bvd_high: assert property (
    (mode == MD_MEM) |=> (multi_status_out && multi_status_oe_out))
    else $error("battery detect not high");
  a_status_changed_n_gated: assert property (
    (mode == MD_IO && !ccsr[CCSR_SIGCHG]) |=> multi_status_out)
    else $error("status change not gated");
  a_status_changed_n_event: assert property (
    (mode == MD_IO && ccsr[CCSR_SIGCHG] && chg_evt && !opt_wr && !ccsr_wr)
      |=> ##1 !multi_status_out)
    else $error("status change not flagged");
  a_task_index: assert property (
    (mode == MD_DISK) |=> (task_index_out == $past(pins.addr[2:0])))
    else $error("task index wrong");
  a_wait_totem: assert property (
    (udma) |=> (io_channel_ready_oe_out && io_channel_ready_out == $past(ctrl[CTL_WAIT])))
    else $error("wait pin not driven");
  a_wait_opendrain: assert property (
    (!udma) |=> !(io_channel_ready_oe_out && io_channel_ready_out))
    else $error("wait pin driven high");
  a_dma_acknowledge_n_ignored: assert property (
    (apb_setup && hit_stat && !ctrl[CTL_DMAEN]) |=> !prdata_out[ST_DMA_ACKNOWLEDGE_N])
    else $error("dma acknowledge seen");
  a_master_sel: assert property (
    (mode == MD_DISK && !pins.cable_select_n) |=> master_out)
    else $error("master not set");

  a_diag_low: assert property (
    (disk) |=> !multi_status_out)
    else $error("diagnostic pin not low");
  a_diag_drive: assert property (
    (disk) |=> (multi_status_oe_out == $past(ctrl[CTL_DIAG])))
    else $error("diagnostic enable wrong");
  a_hstb_write: assert property (
    (apb_setup && hit_stat && udma && ctrl[CTL_UWR])
      |=> (prdata_out[4] == $past(pins.iord_n) && !prdata_out[5]))
    else $error("host strobe not shown");
  a_hrdy_read: assert property (
    (apb_setup && hit_stat && udma && !ctrl[CTL_UWR])
      |=> (prdata_out[5] == $past(pins.iord_n) && !prdata_out[4]))
    else $error("host ready not shown");
  a_cfg_read: assert property (
    (cfg_rd && pins.addr == ATTR_OPTION) |=> (data_lo_oe_out && data_lo_out == $past(option)))
    else $error("option read wrong");
  a_region_cfg: assert property (
    (memio && card_sel && attr && cfg_hit && !io_strobe) |=> (region_out == RG_CONFIG))
    else $error("config region missed");
  a_region_task: assert property (
    (disk && card_sel) |=> (region_out == RG_TASK))
    else $error("task region missed");
  a_word_disk: assert property (
    (disk && !pins.ce1_n && pins.addr[2:0] != 3'h0) |=> !word_access_out)
    else $error("task access not byte");
  a_word_mem: assert property (
    (memio && pins.card_enable_upper_n) |=> !word_access_out)
    else $error("word access without upper enable");
  a_mode_never_init: assert property (
    (mode != MD_INIT) |=> (mode != MD_INIT))
    else $error("mode relatched");
  a_changed_clear: assert property (
    (ccsr_wr && pins_q.data[CCSR_CHANGED] && !chg_evt) |=> !changed)
    else $error("changed flag not cleared");
  a_wait_low: assert property (
    (!udma && !ctrl[CTL_WAIT]) |=> io_channel_ready_oe_out)
    else $error("wait pin not pulled low");
endmodule

// File: chpm_pkg.sv
// chpm_pkg: constants and types of the card host port mode block
// assumes one 125 MHz core clock and an APB register bus
//
// Function
// - output-enable low at power-up selects disk mode
// - config registers sit in attribute space at 200h
// - memory/io modes decode eleven address lines plus attribute
// - disk mode picks task register from three lines
// - memory mode drives battery detect high always
// - io mode flags ready/busy or protect changes low
// - status-changed output gated by config status register
// - disk mode uses diagnostic pin for master/slave handshake
// - without DMA support, acknowledge input is ignored
// - ultra-DMA write: read strobe strobes, wait pin readies
// - ultra-DMA read: read strobe readies, wait pin strobes
// - wait pin totem pole in ultra-DMA, else open-drain
// - disk mode: cable select low means master
// - disk mode: task registers bytes, data transfers words
package chpm_pkg;
  // ==========================================
  // apb register map
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_CONF = 12'h008;
  localparam logic [11:0] REG_ADDR = 12'h00c;
  localparam logic [31:0] CTRL_RST = 32'h0000_0011;
  localparam int CTL_RDY = 0;
  localparam int CTL_WP = 1;
  localparam int CTL_UDMA = 2;
  localparam int CTL_UWR = 3;
  localparam int CTL_WAIT = 4;
  localparam int CTL_DIAG = 5;
  localparam int CTL_DMAEN = 6;
  localparam int CTL_W = 7;
  localparam int ST_DMA_ACKNOWLEDGE_N = 6;
  // ==========================================
  // attribute space configuration registers
  localparam logic [10:0] ATTR_OPTION = 11'h200;
  localparam logic [10:0] ATTR_CCSR = 11'h202;
  localparam logic [1:0] ATTR_CFG_TOP = 2'h1;
  localparam int OPT_IDX_MSB = 5;
  localparam int CCSR_SIGCHG = 6;
  localparam int CCSR_CHANGED = 7;
  localparam logic [7:0] OPT_RST = 8'h00;
  localparam logic [7:0] CCSR_RST = 8'h00;
  // ==========================================
  // timing
  localparam logic [2:0] SETTLE_CYC = 3'h5;
  // ==========================================
  // types
  typedef enum logic [1:0] {MD_INIT, MD_MEM, MD_IO, MD_DISK} chpm_mode_e;
  typedef enum logic [2:0] {RG_NONE, RG_IOPORT, RG_MEMPORT, RG_CIS, RG_CONFIG, RG_TASK}
    chpm_region_e;
  typedef struct packed {
    logic [10:0] addr;
    logic reg_n;
    logic oe_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
    logic ce1_n;
    logic card_enable_upper_n;
    logic cable_select_n;
    logic [7:0] data;
  } chpm_pins_s;
endpackage

// File: chpm_host_model.sv
// chpm_host_model: host controller on the card's parallel pins
// assumes the core clock paces it and the bench calls its tasks
`timescale 1ns/10ps
module chpm_host_model
  import chpm_pkg::*;
(
  input wire logic clk_in,
  output chpm_pins_s pins_out
);
  // ==========================================
  // idle pins
  initial begin
    pins_out = '{addr: 11'h000, reg_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, iord_n: 1'b1,
      iowr_n: 1'b1, ce1_n: 1'b1, card_enable_upper_n: 1'b1, cable_select_n: 1'b1,
      data: 8'h00};
  end
  // ==========================================
  // pin access tasks
  // upper address lines grounded in disk mode
  task automatic drive(input chpm_pins_s p);
    @(posedge clk_in);
    pins_out <= p;
  endtask
  task automatic attr_write(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk_in);
    pins_out.addr <= a;
    pins_out.reg_n <= 1'b0;
    pins_out.ce1_n <= 1'b0;
    pins_out.data <= d;
    repeat (2) @(posedge clk_in);
    pins_out.we_n <= 1'b0;
    repeat (8) @(posedge clk_in);
    pins_out.we_n <= 1'b1;
    repeat (8) @(posedge clk_in);
    pins_out.reg_n <= 1'b1;
    pins_out.ce1_n <= 1'b1;
    pins_out.data <= ~d;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// File: chpm_port_tb.sv
// chpm_port_tb: self-checking bench of the host port mode block
// assumes the host model on the pins and an apb master here
`timescale 1ns/10ps
module chpm_port_tb
  import chpm_pkg::*;
;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} chpm_row_s;
  logic core_clk_in, arst_n_in, psel_in, penable_in, pwrite_in, err, pslverr_out, pready_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [7:0] data_lo_out;
  logic [2:0] task_index_out, region_out;
  logic [1:0] mode_out;
  logic data_lo_oe_out, multi_status_out, multi_status_oe_out, io_channel_ready_out;
  logic io_channel_ready_oe_out, master_out, word_access_out, pin46;
  chpm_pins_s host_pins, p;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int i;
  chpm_row_s rows [7] = '{
    '{1'b0, REG_CTRL, 32'h0, CTRL_RST, 1'b0},
    '{1'b0, 12'h010, 32'h0, 32'h0, 1'b1},
    '{1'b1, REG_CTRL, 32'h53, 32'h0, 1'b0},
    '{1'b0, REG_CTRL, 32'h0, 32'h53, 1'b0},
    '{1'b1, 12'h014, 32'hff, 32'h0, 1'b1},
    '{1'b0, REG_CTRL, 32'h0, 32'h53, 1'b0},
    '{1'b1, REG_CTRL, CTRL_RST, 32'h0, 1'b0}};
  // ==========================================
  // open-drain pin with pull-up
  assign pin46 = multi_status_oe_out ? multi_status_out : 1'b1;
  chpm_port chpm_port_inst (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .host_pins_in(host_pins), .data_lo_out(data_lo_out),
    .data_lo_oe_out(data_lo_oe_out), .multi_status_in(pin46),
    .multi_status_out(multi_status_out), .multi_status_oe_out(multi_status_oe_out),
    .io_channel_ready_out(io_channel_ready_out),
    .io_channel_ready_oe_out(io_channel_ready_oe_out), .mode_out(mode_out),
    .master_out(master_out), .word_access_out(word_access_out),
    .task_index_out(task_index_out), .region_out(region_out));
  chpm_host_model chpm_host_model_inst (.clk_in(core_clk_in), .pins_out(host_pins));
  // ==========================================
  // clock and timeout
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ==========================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic do_reset();
    arst_n_in <= 1'b0;
    repeat (10) @(posedge core_clk_in);
    chk("reset mode", 32'h0, mode_out);
    chk("reset status oe", 32'h0, multi_status_oe_out);
    arst_n_in <= 1'b1;
    repeat (10) @(posedge core_clk_in);
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    arst_n_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    do_reset();
    chk("mode memory", 32'h1, mode_out);
    chk("battery detect", 32'h3, {multi_status_out, multi_status_oe_out});
    foreach (rows[k]) begin
      apb(rows[k].wr, rows[k].a, rows[k].d, rd, err);
      if (!rows[k].wr) chk("apb rdata", rows[k].q, rd);
      chk("apb error", rows[k].e, err);
    end
    chpm_host_model_inst.attr_write(ATTR_OPTION, 8'h01);
    chk("mode io", 32'h2, mode_out);
    chpm_host_model_inst.attr_write(ATTR_CCSR, 8'h40);
    apb(1'b1, REG_CTRL, 32'h10, rd, err);
    for (i = 0; i < 10 && multi_status_out !== 1'b0; i++) @(posedge core_clk_in);
    chk("status changed", 32'h0, multi_status_out);
    apb(1'b0, REG_CONF, 32'h0, rd, err);
    chk("conf", 32'hc001, rd[15:0]);
    apb(1'b0, REG_ADDR, 32'h0, rd, err);
    chk("last address", {21'h0, ATTR_CCSR}, rd);
    // attribute read of the option register
    p = host_pins;
    p.addr = ATTR_OPTION;
    p.reg_n = 1'b0;
    p.ce1_n = 1'b0;
    p.oe_n = 1'b0;
    chpm_host_model_inst.drive(p);
    repeat (8) @(posedge core_clk_in);
    chk("attr read", 32'h101, {data_lo_oe_out, data_lo_out});
    chk("region config", RG_CONFIG, region_out);
    p.oe_n = 1'b1;
    p.reg_n = 1'b1;
    p.ce1_n = 1'b1;
    chpm_host_model_inst.drive(p);
    chpm_host_model_inst.attr_write(ATTR_CCSR, 8'h80);
    chk("status cleared", 32'h1, multi_status_out);
    apb(1'b1, REG_CTRL, 32'h12, rd, err);
    repeat (10) @(posedge core_clk_in);
    chk("status gated", 32'h1, multi_status_out);
    p = host_pins;
    p.addr = 11'h000;
    p.oe_n = 1'b0;
    p.cable_select_n = 1'b0;
    chpm_host_model_inst.drive(p);
    do_reset();
    chk("mode disk", 32'h3, mode_out);
    chk("master", 32'h1, master_out);
    p.oe_n = 1'b1;
    p.addr = 11'h005;
    p.ce1_n = 1'b0;
    p.iord_n = 1'b0;
    p.reg_n = 1'b0;
    chpm_host_model_inst.drive(p);
    repeat (10) @(posedge core_clk_in);
    chk("mode kept", 32'h3, mode_out);
    chk("task index", 32'h5, task_index_out);
    chk("region task", RG_TASK, region_out);
    chk("byte access", 32'h0, word_access_out);
    apb(1'b0, REG_STAT, 32'h0, rd, err);
    chk("dma ack ignored", 32'h0, rd[ST_DMA_ACKNOWLEDGE_N]);
    chk("wait pin released", 32'h0, io_channel_ready_oe_out);
    apb(1'b1, REG_CTRL, 32'h31, rd, err);
    repeat (4) @(posedge core_clk_in);
    chk("diag drive", 32'h2, {multi_status_oe_out, multi_status_out});
    apb(1'b0, REG_STAT, 32'h0, rd, err);
    chk("diag seen", 32'h0, rd[3]);
    p.iord_n = 1'b1;
    chpm_host_model_inst.drive(p);
    apb(1'b1, REG_CTRL, 32'h15, rd, err);
    repeat (4) @(posedge core_clk_in);
    chk("wait pin totem", 32'h3, {io_channel_ready_oe_out, io_channel_ready_out});
    apb(1'b0, REG_STAT, 32'h0, rd, err);
    chk("host ready", 32'h2, rd[5:4]);
    apb(1'b1, REG_CTRL, 32'h1d, rd, err);
    apb(1'b0, REG_STAT, 32'h0, rd, err);
    chk("host strobe", 32'h1, rd[5:4]);
    apb(1'b1, REG_CTRL, 32'h01, rd, err);
    repeat (4) @(posedge core_clk_in);
    chk("wait pin low", 32'h2, {io_channel_ready_oe_out, io_channel_ready_out});
    wrap_up();
  end
endmodule
